// ---- include/fault_trip_pkg.sv ----
// Shared constants, states and carrier types for the fault trip manager.
package fault_trip_pkg;

  // Width of a fault or warning code number.
  localparam int CODE_W = 8;

  // Motor-construction setting value that selects a surface-magnet motor.
  localparam int MOTOR_SEL_W = 4;
  localparam logic [MOTOR_SEL_W-1:0] MOTOR_SPM_SEL = 4'h1;

  // Flash timing: half period of the flashing indications.
  localparam int CLK_KHZ = 200000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_KHZ;
  localparam int BLINK_W = 27;

  // Reset values.
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;

  // Synchroniser bit positions.
  localparam int SYNC_W = 6;
  localparam int SYNC_PANEL = 0;
  localparam int SYNC_DIGITAL = 1;
  localparam int SYNC_SERIAL = 2;
  localparam int SYNC_AUTO = 3;
  localparam int SYNC_MAINS = 4;
  localparam int SYNC_AUTO_ON = 5;

  // Operating state, Gray coded along run, trip, trip lock, wait.
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_TRIP = 2'h1,
    ST_LOCK = 2'h3,
    ST_WAIT_ON = 2'h2
  } trip_state_e;

  // Reset request pins, one per source.
  typedef struct packed {
    logic auto_rst;
    logic serial;
    logic digital;
    logic panel;
  } reset_req_s;

  // Fault report from the detection logic on the same clock.
  typedef struct packed {
    logic present;
    logic serious;
    logic phase_stall;
    logic configurable;
    logic as_alarm;
    logic [CODE_W-1:0] code;
  } fault_rep_s;

  // Warning report from the detection logic on the same clock.
  typedef struct packed {
    logic present;
    logic [CODE_W-1:0] code;
  } warn_rep_s;

endpackage

// ---- design/fault_trip_manager.sv ----
// Fault classification, trip and trip-lock sequencing, and indicators.
//
// Functional notes
// - Every alarm forces trip or trip lock.
// - Reset from panel, input, serial, auto.
// - Trip removes motor drive, logic keeps running.
// - Trip reset accepted only after cause cleared.
// - Only serious faults trip-lock, drive removed.
// - Trip lock rejects resets until power cycled.
// - Warning and alarm lights per system status.
// - Warning code steady, alarm code flashing.
// - Panel reset waits for auto-on to restart.
// - Auto reset never clears a trip lock.
// - Trip flashes both; cleared cause flashes alarm.
// - Surface-magnet setting masks phase and stall faults.
// - Configurable faults report as warning or alarm.
// - After power cycle, lock reset once cleared.
// - Refused reset leaves alarm latched.
module fault_trip_manager
  import fault_trip_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Fault detection and settings
  input wire fault_rep_s fault_i,
  input wire warn_rep_s warn_i,
  input wire logic [MOTOR_SEL_W-1:0] surface_magnet_motor_setting_i,
  // Pins from panel, terminals, fieldbus and supply monitor
  input wire reset_req_s reset_req_i,
  input wire logic mains_restored_i,
  input wire logic auto_on_i,
  // Drive and status
  output logic motor_drive_en_o,
  output trip_state_e state_o,
  // Indicator lights and operator_panel display
  output logic power_led_o,
  output logic warn_led_o,
  output logic alarm_led_o,
  output logic [CODE_W-1:0] display_code_o,
  output logic display_lit_o
);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers and event detection.

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic any_prev_reg;
  logic mains_prev_reg;

  wire logic any_lvl;
  wire logic manual_lvl;
  wire logic panel_lvl;
  wire logic auto_on_lvl;
  wire logic rst_pulse;
  wire logic mains_edge;

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      any_prev_reg <= 1'b0;
      mains_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {auto_on_i, mains_restored_i, reset_req_i};
      sync2_reg <= sync1_reg;
      any_prev_reg <= any_lvl;
      mains_prev_reg <= sync2_reg[SYNC_MAINS];
    end
  end

  assign any_lvl = |sync2_reg[SYNC_AUTO:SYNC_PANEL];
  assign manual_lvl = |sync2_reg[SYNC_SERIAL:SYNC_PANEL];
  assign panel_lvl = sync2_reg[SYNC_PANEL];
  assign auto_on_lvl = sync2_reg[SYNC_AUTO_ON];
  assign rst_pulse = any_lvl & ~any_prev_reg;
  assign mains_edge = sync2_reg[SYNC_MAINS] & ~mains_prev_reg;

  //////////////////////////////////////////////////////////////////////////
  // Fault classification.

  wire logic suppress;
  wire logic cause_live;
  wire logic alarm_eff;
  wire logic warn_eff;

  assign suppress = fault_i.phase_stall
                    & (surface_magnet_motor_setting_i == MOTOR_SPM_SEL);
  assign cause_live = fault_i.present & ~suppress;
  assign alarm_eff = cause_live & (~fault_i.configurable | fault_i.as_alarm);
  assign warn_eff = warn_i.present
                    | (cause_live & fault_i.configurable & ~fault_i.as_alarm);

  //////////////////////////////////////////////////////////////////////////
  // Trip state machine.

  trip_state_e state_reg;
  trip_state_e state_next;
  logic lock_armed_reg;
  logic [CODE_W-1:0] alarm_code_reg;

  wire logic trip_reset_ok;
  wire logic lock_reset_ok;
  wire logic entering_alarm;
  wire trip_state_e alarm_target;
  wire trip_state_e reset_target;

  assign trip_reset_ok = rst_pulse & ~cause_live;
  assign lock_reset_ok = rst_pulse & manual_lvl & ~cause_live
                         & ~lock_armed_reg;
  assign alarm_target = fault_i.serious ? ST_LOCK : ST_TRIP;
  assign reset_target = panel_lvl ? ST_WAIT_ON : ST_RUN;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (alarm_eff)
          state_next = alarm_target;
      end
      ST_WAIT_ON:
      begin
        if (alarm_eff)
          state_next = alarm_target;
        else if (auto_on_lvl)
          state_next = ST_RUN;
      end
      ST_TRIP:
      begin
        if (alarm_eff && fault_i.serious)
          state_next = ST_LOCK;
        else if (trip_reset_ok)
          state_next = reset_target;
      end
      ST_LOCK:
      begin
        if (lock_reset_ok)
          state_next = reset_target;
      end
      default:
        state_next = ST_TRIP;
    endcase
  end

  assign entering_alarm = (state_next == ST_TRIP || state_next == ST_LOCK)
                          && state_next != state_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_RUN;
      lock_armed_reg <= 1'b0;
      alarm_code_reg <= CODE_RST;
    end
    else
    begin
      state_reg <= state_next;
      if (entering_alarm && state_next == ST_LOCK)
        lock_armed_reg <= 1'b1;
      else if (mains_edge)
        lock_armed_reg <= 1'b0;
      if (entering_alarm)
        alarm_code_reg <= fault_i.code;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flash divider.

  logic [BLINK_W-1:0] blink_cnt_reg;
  logic blink_reg;
  wire logic blink_tick;

  assign blink_tick = blink_cnt_reg == BLINK_W'(BLINK_CYCLES - 1);

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end
    else
    begin
      blink_cnt_reg <= blink_tick ? '0 : blink_cnt_reg + 1'b1;
      if (blink_tick)
        blink_reg <= ~blink_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Indicators and outputs.

  wire logic in_alarm;
  wire logic warn_led_next;
  wire logic alarm_led_next;
  wire logic [CODE_W-1:0] code_next;
  wire logic lit_next;

  assign in_alarm = state_reg == ST_TRIP || state_reg == ST_LOCK;
  assign warn_led_next = (state_reg == ST_LOCK) ? 1'b1 :
                         (state_reg == ST_TRIP) ? (cause_live & blink_reg) :
                         warn_eff;
  assign alarm_led_next = in_alarm & blink_reg;
  assign code_next = in_alarm ? alarm_code_reg :
                     warn_eff ? warn_i.code : CODE_RST;
  assign lit_next = in_alarm ? blink_reg : warn_eff;

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      motor_drive_en_o <= 1'b0;
      state_o <= ST_RUN;
      power_led_o <= 1'b0;
      warn_led_o <= 1'b0;
      alarm_led_o <= 1'b0;
      display_code_o <= CODE_RST;
      display_lit_o <= 1'b0;
    end
    else
    begin
      motor_drive_en_o <= state_next == ST_RUN;
      state_o <= state_next;
      power_led_o <= 1'b1;
      warn_led_o <= warn_led_next;
      alarm_led_o <= alarm_led_next;
      display_code_o <= code_next;
      display_lit_o <= lit_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_trip_cleared;
    state_reg == ST_TRIP && !cause_live && !rst_pulse;
  endsequence

  property p_alarm_stops;
    @(posedge core_clk_i) disable iff (!nrst_i)
      alarm_eff |=> !motor_drive_en_o;
  endproperty
  a_alarm_stops: assert property (p_alarm_stops)
    else $error("Alarm left the motor driven.");

  property p_warn_clears;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ST_RUN && !warn_eff) |=> !warn_led_o;
  endproperty
  a_warn_clears: assert property (p_warn_clears)
    else $error("Warning light stayed on after its cause.");

  property p_live_no_reset;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ST_TRIP && cause_live)
        |=> state_reg inside {ST_TRIP, ST_LOCK};
  endproperty
  a_live_no_reset: assert property (p_live_no_reset)
    else $error("Trip released while its cause was live.");

  property p_lock_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ST_LOCK && lock_armed_reg) |=> state_reg == ST_LOCK;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("Trip lock released without a power cycle.");

  property p_auto_no_lock;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ST_LOCK && !manual_lvl) |=> state_reg == ST_LOCK;
  endproperty
  a_auto_no_lock: assert property (p_auto_no_lock)
    else $error("Trip lock cleared without a manual reset.");

  property p_lock_leds;
    @(posedge core_clk_i) disable iff (!nrst_i)
      state_reg == ST_LOCK |=> warn_led_o && alarm_led_o == $past(blink_reg);
  endproperty
  a_lock_leds: assert property (p_lock_leds)
    else $error("Trip lock lights wrong.");

  property p_panel_wait;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ST_WAIT_ON && !auto_on_lvl) |=> !motor_drive_en_o;
  endproperty
  a_panel_wait: assert property (p_panel_wait)
    else $error("Motor restarted without auto-on.");

  property p_reset_pulse;
    @(posedge core_clk_i) disable iff (!nrst_i)
      rst_pulse |=> !rst_pulse;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("Reset pulse lasted more than one cycle.");

  property p_trip_cleared;
    @(posedge core_clk_i) disable iff (!nrst_i)
      s_trip_cleared |=> !warn_led_o && alarm_led_o == $past(blink_reg);
  endproperty
  a_trip_cleared: assert property (p_trip_cleared)
    else $error("Cleared trip shows wrong lights.");

  property p_spm_mask;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ST_RUN && suppress) |=> motor_drive_en_o;
  endproperty
  a_spm_mask: assert property (p_spm_mask)
    else $error("Masked phase or stall fault tripped the drive.");

endmodule

// ---- bench/fault_panel_model.sv ----
// Far-side model: panel key, reset pins, supply monitor and auto-on key.
module fault_panel_model
  import fault_trip_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Pins toward the block
  output reset_req_s reset_req_o,
  output logic mains_restored_o,
  output logic auto_on_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reset_req_o = '0;
    mains_restored_o = 1'b1;
    auto_on_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic press(input reset_req_s r);
    reset_req_o = r;
    hold(4);
    reset_req_o = '0;
    hold(4);
  endtask

  task automatic power_cycle();
    mains_restored_o = 1'b0;
    hold(4);
    mains_restored_o = 1'b1;
    hold(4);
  endtask

  task automatic start_auto();
    auto_on_o = 1'b1;
    hold(4);
    auto_on_o = 1'b0;
    hold(4);
  endtask
endmodule

// ---- bench/fault_trip_manager_tb.sv ----
// Self-checking bench for the fault trip manager.
module fault_trip_manager_tb
  import fault_trip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [1:0] ON = 2'b10;
  localparam logic [1:0] OFF = 2'b01;
  localparam logic [1:0] FL = 2'b11;
  localparam reset_req_s DIG = 4'h2;
  localparam reset_req_s AUT = 4'h8;
  logic core_clk_i;
  logic nrst_i;
  fault_rep_s fault;
  warn_rep_s warn;
  logic [MOTOR_SEL_W-1:0] motor_sel;
  reset_req_s rreq;
  reset_req_s src [5] = '{4'h2, 4'h4, 4'h8, 4'h1, 4'hf};
  logic mains, aon, drv, pwr, wled, aled, lit;
  trip_state_e st;
  logic [CODE_W-1:0] code;
  logic [1:0] a, w, l;
  int fails = 0;
  int total_checks = 0;

  fault_trip_manager #(.BLINK_CYCLES(4)) DUT (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .fault_i(fault),
    .warn_i(warn), .surface_magnet_motor_setting_i(motor_sel),
    .reset_req_i(rreq), .mains_restored_i(mains), .auto_on_i(aon),
    .motor_drive_en_o(drv), .state_o(st), .power_led_o(pwr),
    .warn_led_o(wled), .alarm_led_o(aled), .display_code_o(code),
    .display_lit_o(lit));

  fault_panel_model model (
    .core_clk_i(core_clk_i), .reset_req_o(rreq),
    .mains_restored_o(mains), .auto_on_o(aon));

  task automatic chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic st_chk(input trip_state_e e, input logic d);
    chk("state", {6'h00, st}, {6'h00, e});
    chk("drive", {7'h00, drv}, {7'h00, d});
  endtask

  // Gathers the levels each lamp shows over three flash half periods.
  task automatic lamps(input logic [1:0] ea, ew, el);
    a = 2'b00;
    w = 2'b00;
    l = 2'b00;
    repeat (12)
    begin
      @(negedge core_clk_i);
      a = a | (aled ? ON : OFF);
      w = w | (wled ? ON : OFF);
      l = l | (lit ? ON : OFF);
    end
    chk("alarm_led", {6'h00, a}, {6'h00, ea});
    chk("warn_led", {6'h00, w}, {6'h00, ew});
    chk("display_lit", {6'h00, l}, {6'h00, el});
  endtask

  task automatic flt(input logic s, ph, cf, al, input logic [7:0] c);
    fault = '{1'b1, s, ph, cf, al, c};
    cyc(3);
  endtask

  task automatic clr();
    fault = '0;
    cyc(3);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    #100us;
    fails++;
    end_of_test();
  end

  initial
  begin
    nrst_i = 1'b0;
    fault = '0;
    warn = '0;
    motor_sel = 4'h0;
    cyc(2);
    nrst_i = 1'b1;
    cyc(4);
    st_chk(ST_RUN, 1'b1);
    chk("power_led", {7'h00, pwr}, 8'h01);
    warn = '{1'b1, 8'h05};
    cyc(3);
    lamps(OFF, ON, ON);
    chk("code", code, 8'h05);
    st_chk(ST_RUN, 1'b1);
    warn = '0;
    cyc(3);
    lamps(OFF, OFF, OFF);
    for (int i = 0; i < 5; i++)
    begin
      flt(1'b0, 1'b0, 1'b0, 1'b0, 8'h07);
      st_chk(ST_TRIP, 1'b0);
      lamps(FL, FL, FL);
      chk("code", code, 8'h07);
      model.press(src[i]);
      st_chk(ST_TRIP, 1'b0);
      clr();
      lamps(FL, OFF, FL);
      model.press(src[i]);
      st_chk(src[i].panel ? ST_WAIT_ON : ST_RUN, !src[i].panel);
      if (src[i].panel)
      begin
        model.start_auto();
        st_chk(ST_RUN, 1'b1);
      end
    end
    warn = '{1'b1, 8'h0c};
    flt(1'b0, 1'b0, 1'b0, 1'b0, 8'h0d);
    flt(1'b1, 1'b0, 1'b0, 1'b0, 8'h0d);
    st_chk(ST_LOCK, 1'b0);
    lamps(FL, ON, FL);
    chk("code", code, 8'h0d);
    warn = '0;
    clr();
    model.press(DIG);
    st_chk(ST_LOCK, 1'b0);
    model.power_cycle();
    model.press(AUT);
    st_chk(ST_LOCK, 1'b0);
    model.press(DIG);
    st_chk(ST_RUN, 1'b1);
    motor_sel = MOTOR_SPM_SEL;
    flt(1'b0, 1'b1, 1'b0, 1'b0, 8'h1e);
    st_chk(ST_RUN, 1'b1);
    clr();
    motor_sel = 4'h0;
    flt(1'b0, 1'b1, 1'b0, 1'b0, 8'h1e);
    st_chk(ST_TRIP, 1'b0);
    clr();
    model.press(DIG);
    flt(1'b0, 1'b0, 1'b1, 1'b0, 8'h0a);
    st_chk(ST_RUN, 1'b1);
    lamps(OFF, ON, ON);
    clr();
    flt(1'b0, 1'b0, 1'b1, 1'b1, 8'h0a);
    st_chk(ST_TRIP, 1'b0);
    clr();
    model.press(DIG);
    st_chk(ST_RUN, 1'b1);
    end_of_test();
  end
endmodule
